// File: port_bus_pkg.sv
package port_bus_pkg;

  // Register offsets on the plain register port.
  localparam int unsigned REG_AW = 4;
  localparam logic [3:0] OFS_NIB_DATA = 4'h0;
  localparam logic [3:0] OFS_BIT_DATA = 4'h1;
  localparam logic [3:0] OFS_FIX_DATA = 4'h2;
  localparam logic [3:0] OFS_NIB_MODE = 4'h3;
  localparam logic [3:0] OFS_BIT_DIR = 4'h4;
  localparam logic [3:0] OFS_PORT_CFG = 4'h5;
  localparam logic [3:0] OFS_BUS_CFG = 4'h6;
  localparam logic [3:0] OFS_HS_STAT = 4'h7;

  // Nibble mode codes, one field per nibble.
  localparam logic [1:0] NIB_IN = 2'h0;
  localparam logic [1:0] NIB_OUT = 2'h1;
  localparam logic [1:0] NIB_ADDR = 2'h2;
  localparam int unsigned NIB_LO_POS = 0;
  localparam int unsigned NIB_HI_POS = 2;

  // Port configuration bit positions.
  localparam int unsigned CFG_OPEN_DRAIN = 0;
  localparam int unsigned CFG_NIB_HS = 1;
  localparam int unsigned CFG_BIT_HS = 2;
  localparam int unsigned CFG_SERIAL = 3;
  localparam int unsigned CFG_DSEL = 4;
  localparam int unsigned CFG_TOUT_POS = 5;
  localparam int unsigned BUS_CFG_EXT = 0;

  // Timer output source codes.
  localparam logic [1:0] TOUT_OFF = 2'h0;
  localparam logic [1:0] TOUT_FIRST = 2'h1;
  localparam logic [1:0] TOUT_SECOND = 2'h2;
  localparam logic [1:0] TOUT_CLK = 2'h3;

  // Values after reset.
  localparam logic [3:0] NIB_MODE_RST_LOW = 4'h0;
  localparam logic [3:0] NIB_MODE_RST_HIGH = 4'hA;
  localparam logic [7:0] BIT_DIR_RST = 8'hFF;
  localparam logic [6:0] PORT_CFG_RST = 7'h00;
  localparam logic BUS_EXT_RST_LOW = 1'b1;
  localparam logic BUS_EXT_RST_HIGH = 1'b0;

  // Wait cycles added by extended bus timing.
  localparam int unsigned EXT_WAIT_CYCLES = 2;
  localparam logic [1:0] EXT_WAIT_LAST = 2'(EXT_WAIT_CYCLES - 1);

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic we;
    logic data_space;
  } mem_req_s;

endpackage

// File: bus_cycle_seq.sv
`timescale 1ns/10ps
module bus_cycle_seq (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Core request
  input wire logic req_valid,
  input port_bus_pkg::mem_req_s req,
  output logic req_ready,
  output logic done,
  output logic [7:0] rdata,
  // Timing selection
  input wire logic ext_timing,
  // Bus pins
  output logic addr_strobe_n,
  output logic data_strobe_n,
  output logic rw,
  output logic data_space_select_n,
  output logic [7:0] bus_out,
  output logic [7:0] bus_oe_n,
  input wire logic [7:0] bus_in,
  output logic [7:0] addr_hi
);
  import port_bus_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_HOLD, S_DATA, S_WAIT, S_END
  } seq_state_e;

  seq_state_e state_q;
  mem_req_s cur_q;
  logic ext_q;
  logic [1:0] wait_q;
  logic data_phase;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= S_IDLE;
      wait_q <= 2'h0;
    end else begin
      case (state_q)
        S_IDLE: if (req_valid) state_q <= S_ADDR;
        S_ADDR: state_q <= S_HOLD;
        S_HOLD: state_q <= S_DATA;
        S_DATA: begin
          if (ext_q) begin
            state_q <= S_WAIT;
            wait_q <= EXT_WAIT_LAST;
          end else begin
            state_q <= S_END;
          end
        end
        S_WAIT: begin
          if (wait_q == 2'h0) state_q <= S_END;
          else wait_q <= wait_q - 2'h1;
        end
        S_END: state_q <= S_IDLE;
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // The request and the timing choice are frozen for the whole cycle.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cur_q <= '0;
      ext_q <= 1'b0;
    end else if (state_q == S_IDLE && req_valid) begin
      cur_q <= req;
      ext_q <= ext_timing; // [RULE10] [RULE12]
    end
  end

  // Read data are taken while the data strobe is still low.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 8'h00;
    end else if (!cur_q.we && (state_q == S_DATA && !ext_q ||
                 state_q == S_WAIT && wait_q == 2'h0)) begin
      rdata <= bus_in;
    end
  end

  assign data_phase = state_q == S_DATA || state_q == S_WAIT ||
                      state_q == S_END;
  assign req_ready = state_q == S_IDLE;
  assign done = state_q == S_END;
  assign addr_strobe_n = !(state_q == S_ADDR); // [RULE19] [RULE2]
  assign data_strobe_n = !(state_q == S_DATA || state_q == S_WAIT); // [RULE20]
  assign rw = !(cur_q.we && state_q != S_IDLE); // [RULE21]
  assign data_space_select_n = !(cur_q.data_space && state_q != S_IDLE);
  // Low address lines, then data, on the same eight lines. [RULE1]
  assign bus_out = data_phase ? cur_q.wdata : cur_q.addr[7:0];
  // Outside a read data phase the lines are driven: address, or write data in a write data phase. [RULE3]
  assign bus_oe_n = {8{data_phase && !cur_q.we}};
  assign addr_hi = cur_q.addr[15:8];

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  as_pulse_a: assert property ( // [RULE19]
    $fell(addr_strobe_n) |=> addr_strobe_n ##1 addr_strobe_n)
    else $error("address strobe pulse not one cycle");

  addr_valid_a: assert property ( // [RULE19]
    !addr_strobe_n |=> bus_oe_n == 8'h00 && bus_out == $past(bus_out))
    else $error("address not stable at strobe trailing edge");

  ds_once_a: assert property ( // [RULE20]
    $fell(addr_strobe_n) |=> data_strobe_n ##1 $fell(data_strobe_n))
    else $error("data strobe not asserted after address strobe");

  ext_wait_a: assert property ( // [RULE10]
    $fell(data_strobe_n) && ext_q |-> !data_strobe_n [*3] ##1 data_strobe_n)
    else $error("extended timing did not add two wait cycles");

  fast_time_a: assert property ( // [RULE12]
    $fell(data_strobe_n) && !ext_q |=> data_strobe_n)
    else $error("fast timing strobe too long");

  rw_level_a: assert property ( // [RULE21]
    $fell(addr_strobe_n) |-> rw == !$past(req.we) [*4])
    else $error("read/write level wrong in cycle");

  cycle_done_a: assert property ( // [RULE2]
    $fell(addr_strobe_n) |-> ##[3:5] done)
    else $error("bus cycle did not complete in time");

  write_cyc_c: cover property ($fell(addr_strobe_n) && !rw);
  read_ext_c: cover property ($fell(data_strobe_n) && ext_q && rw);
  read_fast_c: cover property ($fell(data_strobe_n) && !ext_q && rw);

endmodule

// File: port_and_memory_bus_config.sv
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/10ps
// Functional notes
// RULE1: Mux bus port carries low address then data; no register, no handshake.
// RULE2: Bus cycles are sequenced by address/data strobe, read/write, space select.
// RULE3: After reset all mux bus lines drive address for both variants.
// RULE4: Nibble port lower nibble gives A8-A11; both nibbles give A8-A15.
// RULE5: With twelve address bits the upper nibble may stay ordinary I/O.
// RULE6: Nibble port handshake uses fixed port lines two and five.
// RULE7: Nibble handshake roles follow the upper nibble direction.
// RULE8: Low-boundary variant: nibble port floats as input until configured.
// RULE9: Software writes upper address first, then sets nibble address mode.
// RULE10: Low-boundary variant starts with two extra wait cycles, software clears.
// RULE11: High-boundary variant starts with nibble port driving A8-A15.
// RULE12: High-boundary variant starts in fast timing with no wait cycles.
// RULE13: Bit port lines have own direction; whole port may be open drain.
// RULE14: Bit port handshake on lines one and six, roles from bit seven.
// RULE15: Fixed port lines zero-three are inputs, four-seven outputs.
// RULE16: Serial enabled: line zero is serial in, line seven serial out.
// RULE17: Fixed port offers handshake, interrupt inputs, timer in/out, space select.
// RULE18: Line six may output first timer, second timer or internal clock.
// RULE19: Address strobe pulses low once per cycle; address valid at its end.
// RULE20: Data strobe goes low exactly once per external transfer.
// RULE21: Read/write is low for external writes and high otherwise.
// RULE22: Data space select may be routed to fixed port line four.
module port_and_memory_bus_config #(
  parameter bit LOW_BOUNDARY = 1'b1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Register port
  input wire logic [port_bus_pkg::REG_AW-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Core memory request
  input wire logic mem_req_valid,
  input port_bus_pkg::mem_req_s mem_req,
  output logic mem_req_ready,
  output logic mem_done,
  output logic [7:0] mem_rdata,
  // Companion functions
  input wire logic serial_tx_bit,
  output logic serial_rx_bit,
  output logic [3:0] ext_int_req_lines,
  output logic timer_in,
  input wire logic first_timer_out,
  input wire logic second_timer_out,
  input wire logic internal_clk,
  // Memory bus pins
  output logic addr_strobe_n,
  output logic data_strobe_n,
  output logic rw,
  input wire logic [7:0] mux_bus_port_in,
  output logic [7:0] mux_bus_port_out,
  output logic [7:0] mux_bus_port_oe_n,
  // Nibble port pins
  input wire logic [7:0] addr_nibble_port_in,
  output logic [7:0] addr_nibble_port_out,
  output logic [7:0] addr_nibble_port_oe_n,
  // Bit programmable port pins
  input wire logic [7:0] bit_io_port_in,
  output logic [7:0] bit_io_port_out,
  output logic [7:0] bit_io_port_oe_n,
  // Fixed direction port: lines 0-3 in, lines 4-7 out
  input wire logic [3:0] fixed_dir_port_in,
  output logic [3:0] fixed_dir_port_out
);
  import port_bus_pkg::*;

  localparam logic [3:0] NIB_MODE_RST =
    LOW_BOUNDARY ? NIB_MODE_RST_LOW : NIB_MODE_RST_HIGH;
  localparam logic BUS_EXT_RST =
    LOW_BOUNDARY ? BUS_EXT_RST_LOW : BUS_EXT_RST_HIGH;

  function automatic logic reg_hit(input logic [REG_AW-1:0] a,
                                   input logic [REG_AW-1:0] ofs);
    reg_hit = a == ofs;
  endfunction

  logic [7:0] nib_data_q;
  logic [7:0] bit_data_q;
  logic [3:0] fix_out_q;
  logic [3:0] nib_mode_q;
  logic [7:0] bit_dir_q;
  logic [6:0] port_cfg_q;
  logic ext_timing_q;
  logic nib_mode_set_q;
  logic [1:0] hs_pend_q;
  logic [7:0] hs_data_q [2];
  logic [1:0] hs_en;
  logic [1:0] hs_dir_out;
  logic [1:0] hs_in_line;
  logic [1:0] hs_out_line;
  logic [1:0] hs_wr;
  logic [1:0] hs_rd;
  logic [7:0] hs_port_in [2];
  logic [1:0] nib_lo_mode;
  logic [1:0] nib_hi_mode;
  logic [7:0] addr_hi;
  logic data_space_select_n;
  logic [1:0] tout_sel;
  logic tout_bit;
  logic [7:0] nib_rd;
  logic [7:0] bit_rd;
  logic wr_nib_data;
  logic wr_bit_data;
  logic wr_nib_mode;

  assign wr_nib_data = reg_wr && reg_hit(reg_addr, OFS_NIB_DATA);
  assign wr_bit_data = reg_wr && reg_hit(reg_addr, OFS_BIT_DATA);
  assign wr_nib_mode = reg_wr && reg_hit(reg_addr, OFS_NIB_MODE);

  // The mux bus port has no register of its own; only the sequencer owns it.
  bus_cycle_seq u_seq (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .req_valid(mem_req_valid),
    .req(mem_req),
    .req_ready(mem_req_ready),
    .done(mem_done),
    .rdata(mem_rdata),
    .ext_timing(ext_timing_q),
    .addr_strobe_n(addr_strobe_n),
    .data_strobe_n(data_strobe_n),
    .rw(rw),
    .data_space_select_n(data_space_select_n),
    .bus_out(mux_bus_port_out),
    .bus_oe_n(mux_bus_port_oe_n),
    .bus_in(mux_bus_port_in),
    .addr_hi(addr_hi)
  ); // [RULE1] [RULE2]

  // Port output latches.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      nib_data_q <= 8'h00;
      bit_data_q <= 8'h00;
      fix_out_q <= 4'h0;
    end else begin
      if (wr_nib_data) nib_data_q <= reg_wdata;
      if (wr_bit_data) bit_data_q <= reg_wdata;
      if (reg_wr && reg_hit(reg_addr, OFS_FIX_DATA)) begin
        fix_out_q <= reg_wdata[7:4];
      end
    end
  end

  // Mode and configuration registers; nibble mode and bus timing reset values depend on the variant.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      nib_mode_q <= NIB_MODE_RST; // [RULE8] [RULE11]
      bit_dir_q <= BIT_DIR_RST;
      port_cfg_q <= PORT_CFG_RST;
      ext_timing_q <= BUS_EXT_RST; // [RULE10] [RULE12]
    end else begin
      if (wr_nib_mode) nib_mode_q <= reg_wdata[3:0];
      if (reg_wr && reg_hit(reg_addr, OFS_BIT_DIR)) bit_dir_q <= reg_wdata;
      if (reg_wr && reg_hit(reg_addr, OFS_PORT_CFG)) begin
        port_cfg_q <= reg_wdata[6:0];
      end
      if (reg_wr && reg_hit(reg_addr, OFS_BUS_CFG)) begin
        ext_timing_q <= reg_wdata[BUS_CFG_EXT];
      end
    end
  end

  // Remembers whether software has ever set the nibble port mode.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) nib_mode_set_q <= 1'b0;
    else if (wr_nib_mode) nib_mode_set_q <= 1'b1;
  end

  // Nibble port: each nibble is input, output or upper address.
  // Software must load the address latch before choosing address mode,
  // otherwise the routine running from floating lines is lost. [RULE9]
  assign nib_lo_mode = nib_mode_q[NIB_LO_POS +: 2];
  assign nib_hi_mode = nib_mode_q[NIB_HI_POS +: 2];
  assign addr_nibble_port_out[3:0] =
    nib_lo_mode == NIB_ADDR ? addr_hi[3:0] : nib_data_q[3:0]; // [RULE4]
  assign addr_nibble_port_out[7:4] =
    nib_hi_mode == NIB_ADDR ? addr_hi[7:4] : nib_data_q[7:4]; // [RULE5]
  assign addr_nibble_port_oe_n[3:0] =
    {4{!(nib_lo_mode == NIB_OUT || nib_lo_mode == NIB_ADDR)}}; // [RULE8]
  assign addr_nibble_port_oe_n[7:4] =
    {4{!(nib_hi_mode == NIB_OUT || nib_hi_mode == NIB_ADDR)}}; // [RULE5]

  // Bit port: per-line direction, 1 = input; open drain drives only zeros.
  assign bit_io_port_out = bit_data_q;
  assign bit_io_port_oe_n = bit_dir_q |
    ({8{port_cfg_q[CFG_OPEN_DRAIN]}} & bit_data_q); // [RULE13]

  // Handshake channels: index 0 serves the nibble port, 1 the bit port.
  assign hs_en[0] = port_cfg_q[CFG_NIB_HS]; // [RULE6]
  assign hs_en[1] = port_cfg_q[CFG_BIT_HS]; // [RULE14]
  assign hs_dir_out[0] = nib_hi_mode == NIB_OUT; // [RULE7]
  assign hs_dir_out[1] = !bit_dir_q[7]; // [RULE14]
  assign hs_in_line[0] = fixed_dir_port_in[2]; // [RULE6]
  assign hs_in_line[1] = fixed_dir_port_in[1]; // [RULE14]
  assign hs_wr = {wr_bit_data, wr_nib_data};
  assign hs_rd[0] = reg_rd && reg_hit(reg_addr, OFS_NIB_DATA);
  assign hs_rd[1] = reg_rd && reg_hit(reg_addr, OFS_BIT_DATA);
  assign hs_port_in[0] = addr_nibble_port_in;
  assign hs_port_in[1] = bit_io_port_in;

  // Output direction: a write raises pending, valid goes low until the
  // peer shows ready low. Input direction: valid low latches the pins and
  // holds ready high until software reads. A new event beats a clear.
  for (genvar c = 0; c < 2; c++) begin : g_hs
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        hs_pend_q[c] <= 1'b0;
        hs_data_q[c] <= 8'h00;
      end else if (!hs_en[c]) begin
        hs_pend_q[c] <= 1'b0;
      end else if (hs_dir_out[c]) begin
        if (hs_wr[c]) hs_pend_q[c] <= 1'b1;
        else if (!hs_in_line[c]) hs_pend_q[c] <= 1'b0;
      end else begin
        if (!hs_in_line[c] && !hs_pend_q[c]) begin
          hs_pend_q[c] <= 1'b1;
          hs_data_q[c] <= hs_port_in[c];
        end else if (hs_rd[c]) begin
          hs_pend_q[c] <= 1'b0;
        end
      end
    end
    // Valid is active low when sending; ready is active high when receiving.
    assign hs_out_line[c] = hs_dir_out[c] ? !hs_pend_q[c] : hs_pend_q[c];
  end

  // Fixed direction port, lines 4-7, each either a latch bit or a function.
  assign tout_sel = port_cfg_q[CFG_TOUT_POS +: 2];
  always_comb begin
    case (tout_sel)
      TOUT_FIRST: tout_bit = first_timer_out; // [RULE18]
      TOUT_SECOND: tout_bit = second_timer_out;
      TOUT_CLK: tout_bit = internal_clk;
      default: tout_bit = fix_out_q[2];
    endcase
  end

  assign fixed_dir_port_out[0] = port_cfg_q[CFG_DSEL] ?
    data_space_select_n : fix_out_q[0]; // [RULE22]
  assign fixed_dir_port_out[1] = hs_en[0] ? hs_out_line[0] : fix_out_q[1];
  // Handshake takes line six over the timer output when both are chosen.
  assign fixed_dir_port_out[2] = hs_en[1] ? hs_out_line[1] : tout_bit;
  assign fixed_dir_port_out[3] = port_cfg_q[CFG_SERIAL] ?
    serial_tx_bit : fix_out_q[3]; // [RULE16]

  // Lines 0-3 are inputs only and fan out to their alternate users.
  assign serial_rx_bit = fixed_dir_port_in[0]; // [RULE16]
  assign ext_int_req_lines = fixed_dir_port_in; // [RULE17]
  assign timer_in = fixed_dir_port_in[1]; // [RULE17]

  // Read values of the two bidirectional ports.
  always_comb begin
    nib_rd[3:0] = nib_lo_mode == NIB_OUT ? nib_data_q[3:0] :
                  addr_nibble_port_in[3:0];
    nib_rd[7:4] = nib_hi_mode == NIB_OUT ? nib_data_q[7:4] :
                  addr_nibble_port_in[7:4];
    if (hs_en[0] && !hs_dir_out[0]) nib_rd = hs_data_q[0];
    bit_rd = (bit_dir_q & bit_io_port_in) | (~bit_dir_q & bit_data_q);
    if (hs_en[1] && !hs_dir_out[1]) bit_rd = hs_data_q[1];
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (!reg_rd) begin
      reg_rdata <= 8'h00;
    end else begin
      case (reg_addr)
        OFS_NIB_DATA: reg_rdata <= nib_rd;
        OFS_BIT_DATA: reg_rdata <= bit_rd;
        OFS_FIX_DATA: reg_rdata <= {fix_out_q, fixed_dir_port_in}; // [RULE15]
        OFS_NIB_MODE: reg_rdata <= {4'h0, nib_mode_q};
        OFS_BIT_DIR: reg_rdata <= bit_dir_q;
        OFS_PORT_CFG: reg_rdata <= {1'b0, port_cfg_q};
        OFS_BUS_CFG: reg_rdata <= {7'h00, ext_timing_q};
        OFS_HS_STAT: reg_rdata <= {6'h00, hs_pend_q};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  nib_float_a: assert property ( // [RULE8]
    LOW_BOUNDARY && !nib_mode_set_q |-> addr_nibble_port_oe_n == 8'hFF)
    else $error("nibble port driven before configuration");

  nib_addr_a: assert property ( // [RULE11]
    !LOW_BOUNDARY && !nib_mode_set_q |->
      addr_nibble_port_oe_n == 8'h00 && addr_nibble_port_out == addr_hi)
    else $error("nibble port not driving upper address");

  open_drain_a: assert property ( // [RULE13]
    port_cfg_q[CFG_OPEN_DRAIN] |->
      (~bit_io_port_oe_n & bit_io_port_out) == 8'h00)
    else $error("open drain port drove a one");

  nib_valid_a: assert property ( // [RULE6]
    wr_nib_data && hs_en[0] && hs_dir_out[0] |=>
      !fixed_dir_port_out[1] && hs_pend_q[0])
    else $error("nibble handshake valid not asserted after write");

  bit_ready_a: assert property ( // [RULE14]
    hs_en[1] && !hs_dir_out[1] && !hs_pend_q[1] && !hs_in_line[1]
      ##1 !hs_rd[1] && hs_en[1] && !hs_dir_out[1] |->
      fixed_dir_port_out[2] && hs_data_q[1] == $past(bit_io_port_in, 1))
    else $error("bit port ready or latch wrong after valid");

  fix_read_a: assert property ( // [RULE15]
    reg_rd && reg_addr == OFS_FIX_DATA |=>
      reg_rdata == {$past(fix_out_q), $past(fixed_dir_port_in)})
    else $error("fixed port read value wrong");

  tout_first_a: assert property ( // [RULE18]
    tout_sel == TOUT_FIRST && !hs_en[1] |->
      fixed_dir_port_out[2] == first_timer_out)
    else $error("timer output not routed");

  dsel_line_a: assert property ( // [RULE22]
    port_cfg_q[CFG_DSEL] && $fell(addr_strobe_n) |->
      fixed_dir_port_out[0] == !$past(mem_req.data_space))
    else $error("space select line wrong in bus cycle");

  serial_out_a: assert property ( // [RULE16]
    port_cfg_q[CFG_SERIAL] |-> fixed_dir_port_out[3] == serial_tx_bit)
    else $error("serial output not on line seven");

  nib_hs_c: cover property (hs_en[0] && $fell(hs_out_line[0]));
  split_nib_c: cover property (nib_lo_mode == NIB_ADDR &&
                               nib_hi_mode == NIB_OUT);

endmodule

// File: ext_mem_model.sv
`timescale 1ns/10ps
module ext_mem_model (
  // Bus pins seen from the memory side
  input wire logic addr_strobe_n,
  input wire logic data_strobe_n,
  input wire logic rw,
  input wire logic [7:0] bus_out,
  input wire logic [7:0] bus_oe_n,
  // Data returned to the device
  output logic [7:0] bus_in
);
  logic [7:0] mem_q [256];
  logic [7:0] addr_q = 8'h00;
  logic [7:0] last_q = 8'h00;
  logic drive;
  initial begin
    for (int i = 0; i < 256; i++) mem_q[i] = 8'(i);
  end
  always @(posedge addr_strobe_n) addr_q = bus_out;
  always @(posedge data_strobe_n) begin
    if (!rw) mem_q[addr_q] = bus_out;
  end
  always @(negedge data_strobe_n) begin
    if (rw) last_q = mem_q[addr_q];
  end
  assign drive = !data_strobe_n && rw && (bus_oe_n === 8'hFF);
  // A released bus shows the inverted last byte, so stale data never passes.
  assign bus_in = drive ? mem_q[addr_q] : ~last_q;
endmodule

// File: port_and_memory_bus_config_tb.sv
`timescale 1ns/10ps
`define CHK(n, e, s) begin total_checks++; if ((e) !== (s)) begin \
  bad_count++; $display("wrong value %s exp %h got %h", n, e, s); end end
module port_and_memory_bus_config_tb;
  import port_bus_pkg::*;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic mem_req_valid = 1'b0;
  mem_req_s mem_req = '0;
  logic [7:0] nib_i = 8'h00, bio_i = 8'h00;
  logic [3:0] fix_i = 4'h0;
  logic ser_tx = 1'b0, t0 = 1'b0, t1 = 1'b0, iclk = 1'b0;
  logic [7:0] reg_rdata, mem_rdata, mux_o, mux_oe, mux_i, nib_o, nib_oe;
  logic [7:0] bio_o, bio_oe, mexp, d, hi, r;
  logic [3:0] fix_o, irq;
  logic mem_req_ready, mem_done, ser_rx, t_in, as_n, ds_n, rw;
  logic [15:0] a;
  logic [7:0] rq [$];
  logic [7:0] mq [$];
  logic rd_seen = 1'b0;
  logic nib_chk = 1'b0;
  logic [7:0] nib_exp_g = 8'h00;
  logic [7:0] rdh, nib_oh, nib_oeh;
  int bad_count = 0;
  int total_checks = 0;
  logic [31:0] seed = 32'd1830;

  always #2.5 core_clk = ~core_clk;

  port_and_memory_bus_config dut_u (
    .core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .mem_req_valid(mem_req_valid), .mem_req(mem_req),
    .mem_req_ready(mem_req_ready), .mem_done(mem_done),
    .mem_rdata(mem_rdata), .serial_tx_bit(ser_tx), .serial_rx_bit(ser_rx),
    .ext_int_req_lines(irq), .timer_in(t_in), .first_timer_out(t0),
    .second_timer_out(t1), .internal_clk(iclk), .addr_strobe_n(as_n),
    .data_strobe_n(ds_n), .rw(rw), .mux_bus_port_in(mux_i),
    .mux_bus_port_out(mux_o), .mux_bus_port_oe_n(mux_oe),
    .addr_nibble_port_in(nib_i), .addr_nibble_port_out(nib_o),
    .addr_nibble_port_oe_n(nib_oe), .bit_io_port_in(bio_i),
    .bit_io_port_out(bio_o), .bit_io_port_oe_n(bio_oe),
    .fixed_dir_port_in(fix_i), .fixed_dir_port_out(fix_o)
  );

  // The high-boundary variant runs beside the other on the same stimulus.
  port_and_memory_bus_config #(.LOW_BOUNDARY(1'b0)) dut_hi_u (
    .core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(rdh), .mem_req_valid(mem_req_valid), .mem_req(mem_req),
    .mem_req_ready(), .mem_done(), .mem_rdata(), .serial_tx_bit(ser_tx),
    .serial_rx_bit(), .ext_int_req_lines(), .timer_in(),
    .first_timer_out(t0), .second_timer_out(t1), .internal_clk(iclk),
    .addr_strobe_n(), .data_strobe_n(), .rw(), .mux_bus_port_in(mux_i),
    .mux_bus_port_out(), .mux_bus_port_oe_n(),
    .addr_nibble_port_in(nib_i), .addr_nibble_port_out(nib_oh),
    .addr_nibble_port_oe_n(nib_oeh), .bit_io_port_in(bio_i),
    .bit_io_port_out(), .bit_io_port_oe_n(),
    .fixed_dir_port_in(fix_i), .fixed_dir_port_out()
  );

  ext_mem_model mem_u (
    .addr_strobe_n(as_n), .data_strobe_n(ds_n), .rw(rw),
    .bus_out(mux_o), .bus_oe_n(mux_oe), .bus_in(mux_i)
  );

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic wrap_up();
    if (bad_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wr(input logic [3:0] ofs, input logic [7:0] val);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= ofs;
    reg_wdata <= val;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // The expected byte is queued when the read is issued.
  task automatic rd(input logic [3:0] ofs, input logic [7:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= ofs;
    rq.push_back(exp);
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask

  task automatic mem(input logic [15:0] ad, input logic [7:0] dt,
                     input logic w, input logic ext);
    int n, ds, as_c, rwl;
    n = 0;
    ds = 0;
    as_c = 0;
    rwl = 0;
    @(posedge core_clk);
    mem_req_valid <= 1'b1;
    mem_req <= '{ad, dt, w, 1'b0};
    if (!w) mq.push_back(dt);
    @(posedge core_clk);
    mem_req_valid <= 1'b0;
    do begin
      @(posedge core_clk);
      n++;
      if (as_n === 1'b0) begin
        as_c++;
        `CHK("low addr", ad[7:0], mux_o)
        `CHK("busy", 1'b0, mem_req_ready)
        if (nib_chk) `CHK("high addr", nib_exp_g, nib_o)
      end
      if (ds_n === 1'b0) begin
        ds++;
        rwl += (rw === 1'b0);
      end
    end while (mem_done !== 1'b1 && n < 20);
    `CHK("cycle len", 4 + (ext ? EXT_WAIT_CYCLES : 0), n)
    `CHK("addr strobes", 1, as_c)
    `CHK("data strobe", 1 + (ext ? EXT_WAIT_CYCLES : 0), ds)
    `CHK("rw low", w ? ds : 0, rwl)
  endtask

  always @(posedge core_clk) begin
    nib_i <= 8'(xs());
    bio_i <= 8'(xs());
    fix_i <= 4'(xs());
  end

  always @(posedge core_clk) begin
    if (rd_seen) begin
      mexp = rq.pop_front();
      `CHK("reg_rdata", mexp, reg_rdata)
    end
    rd_seen = reg_rd;
    if (mem_done === 1'b1 && mq.size() > 0) begin
      mexp = mq.pop_front();
      `CHK("mem_rdata", mexp, mem_rdata)
    end
  end

  initial begin
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    @(negedge core_clk);
    `CHK("nib oe", 8'hFF, nib_oe)
    `CHK("mux oe", 8'h00, mux_oe)
    `CHK("hi nib oe", 8'h00, nib_oeh)
    `CHK("hi nib out", 8'h00, nib_oh)
    rd(OFS_NIB_MODE, 8'(NIB_MODE_RST_LOW));
    rd(OFS_BUS_CFG, 8'(BUS_EXT_RST_LOW));
    @(negedge core_clk);
    `CHK("hi ext", 8'(BUS_EXT_RST_HIGH), rdh)
    rd(OFS_BIT_DIR, BIT_DIR_RST);
    rd(4'h8, 8'h00);
    mem(16'h0012, 8'h3C, 1'b1, 1'b1);
    mem(16'h0012, 8'h3C, 1'b0, 1'b1);
    hi = 8'(xs());
    wr(OFS_NIB_DATA, hi);
    wr(OFS_BUS_CFG, 8'h00);
    nib_chk = 1'b1;
    // Full address mode first, then low nibble address with upper as output.
    for (int i = 0; i < 2; i++) begin
      wr(OFS_NIB_MODE, i ? 8'h06 : 8'h0A);
      a = 16'(xs());
      d = 8'(xs());
      nib_exp_g = i ? {hi[7:4], a[11:8]} : a[15:8];
      mem(a, d, 1'b1, 1'b0);
      mem(a, d, 1'b0, 1'b0);
    end
    for (int c = 0; c < 4; c++) begin
      wr(OFS_PORT_CFG, 8'((c << CFG_TOUT_POS) | (1 << CFG_SERIAL) | (c & 1)));
      {t0, t1, iclk, ser_tx} <= 4'(xs());
      @(negedge core_clk);
      `CHK("line7", ser_tx, fix_o[3])
      `CHK("line6", c == 0 ? 1'b0 : c == 1 ? t0 : c == 2 ? t1 : iclk,
           fix_o[2])
      `CHK("irq lines", fix_i, irq)
      `CHK("serial in", fix_i[0], ser_rx)
      `CHK("timer in", fix_i[1], t_in)
    end
    r = 8'(xs());
    d = 8'(xs());
    wr(OFS_BIT_DATA, d);
    wr(OFS_BIT_DIR, r);
    @(negedge core_clk);
    // Open drain is on here, so a one in the latch releases its line.
    `CHK("bit oe", r | d, bio_oe)
    `CHK("bit out", d, bio_o)
    rd(OFS_BIT_DIR, r);
    wr(OFS_PORT_CFG, 8'(1 << CFG_NIB_HS));
    wr(OFS_NIB_DATA, d);
    @(negedge core_clk);
    `CHK("nib valid", 1'b0, fix_o[1])
    repeat (3) @(posedge core_clk);
    wrap_up();
  end
endmodule
